//--- verilog/srco_core.sv
`timescale 1ns/1ps
// Summary of operation
// [RULE_01] Rotate right sets overflow on carry out.
// [RULE_02] Rotate carry is last bit out.
// [RULE_03] Rotate moves bit zero to top, carry.
// [RULE_04] Zero, negative from result; end flag cleared.
// [RULE_05] Enabled software break enters break mode.
// [RULE_06] Otherwise raise class A trap, flags kept.
// [RULE_07] Context switch pushes old value below stack.
// [RULE_08] Then loads register with second operand.
// [RULE_09] Left shift fills low bits with zeros.
// [RULE_10] Left shift carry is last top bit.
// [RULE_11] Right shift fills high bits with zeros.
// [RULE_12] Right shift overflow accumulates previous carries.
// [RULE_13] Carry and overflow give rounding information.
// [RULE_14] Right shift count zero clears overflow.
// [RULE_15] Software keeps counts within zero to fifteen.
// [RULE_16] Only low four count bits used.
// [RULE_17] Zero count leaves operand value unchanged.
module srco_core
	import srco_pkg::*;
#(
	parameter int W = SRCO_W
) (
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_valid,
	input wire srco_req_t i_req,
	input wire srco_flags_t i_flags,
	input wire logic [15:0] i_stack_pointer,
	input wire logic i_onchip_emulation_logic_software_break_op_en,
	output logic o_done,
	output logic [W-1:0] o_result,
	output logic o_wr_en,
	output logic [3:0] o_wr_sel,
	output srco_flags_t o_flags,
	output logic o_flags_wr,
	output logic [15:0] o_stack_pointer,
	output logic o_sp_wr,
	output logic [15:0] o_mem_addr,
	output logic [15:0] o_mem_wdata,
	output logic o_mem_wr,
	output logic o_break_mode,
	output logic o_trap,
	output logic [7:0] o_trap_vector
);

	// Shifter outputs.
	logic [W-1:0] sh_res;
	srco_flags_t sh_flags;
	// Output registers.
	logic done_ff;
	logic [W-1:0] result_ff;
	logic wr_en_ff;
	logic [3:0] wr_sel_ff;
	srco_flags_t flags_ff;
	logic flags_wr_ff;
	logic [15:0] sp_ff;
	logic sp_wr_ff;
	logic [15:0] addr_ff;
	logic [15:0] wdata_ff;
	logic mem_wr_ff;
	logic brk_ff;
	logic trap_ff;
	logic [7:0] vec_ff;
	// Decremented stack pointer for the context switch.
	logic [15:0] nxt_sp;

	// Shift and rotate datapath.
	srco_shifter #(
		.W(W)
	) u_shifter (
		.i_op(i_req.op),
		.i_val(i_req.op1),
		.i_cnt_raw(i_req.op2),
		.i_v_old(i_flags.v),
		.o_res(sh_res),
		.o_flags(sh_flags)
	);

	// The new stack slot lies one word below the current top.
	assign nxt_sp = i_stack_pointer - SRCO_SP_STEP; // [RULE_07]

	// Register write-back and flag update for shifts and the switch.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			done_ff <= 1'b0;
			result_ff <= SRCO_WORD_RST;
			wr_en_ff <= 1'b0;
			wr_sel_ff <= 4'h0;
			flags_ff <= '0;
			flags_wr_ff <= 1'b0;
		end else begin
			done_ff <= i_valid;
			wr_en_ff <= 1'b0;
			flags_wr_ff <= 1'b0;
			if (i_valid) begin
				wr_sel_ff <= i_req.reg_sel;
				// Flags pass through unless an operation changes them.
				flags_ff <= i_flags; // [RULE_06]
				case (i_req.op)
					SRCO_OP_ROR, SRCO_OP_SHL, SRCO_OP_SHR: begin
						result_ff <= sh_res;
						wr_en_ff <= 1'b1;
						flags_ff <= sh_flags; // [RULE_04]
						flags_wr_ff <= 1'b1;
					end
					SRCO_OP_CONTEXT_SWITCH_OP: begin
						result_ff <= i_req.op2; // [RULE_08]
						wr_en_ff <= 1'b1;
					end
					default: begin
						result_ff <= result_ff;
					end
				endcase
			end
		end
	end

	// Stack push of the old register value for the context switch.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			sp_ff <= SRCO_WORD_RST;
			sp_wr_ff <= 1'b0;
			addr_ff <= SRCO_WORD_RST;
			wdata_ff <= SRCO_WORD_RST;
			mem_wr_ff <= 1'b0;
		end else begin
			sp_wr_ff <= 1'b0;
			mem_wr_ff <= 1'b0;
			if (i_valid && i_req.op == SRCO_OP_CONTEXT_SWITCH_OP) begin
				sp_ff <= nxt_sp; // [RULE_07]
				sp_wr_ff <= 1'b1;
				addr_ff <= nxt_sp;
				wdata_ff <= i_req.op1; // [RULE_07]
				mem_wr_ff <= 1'b1;
			end
		end
	end

	// Software break: break mode when enabled, otherwise the trap pulse.
	always_ff @(posedge i_clk) begin
		if (!i_nrst) begin
			brk_ff <= 1'b0;
			trap_ff <= 1'b0;
			vec_ff <= 8'h00;
		end else begin
			trap_ff <= 1'b0;
			if (i_valid && i_req.op == SRCO_OP_SOFTWARE_BREAK_OP) begin
				if (i_onchip_emulation_logic_software_break_op_en) begin
					brk_ff <= 1'b1; // [RULE_05]
				end else begin
					trap_ff <= 1'b1; // [RULE_06]
					vec_ff <= SRCO_SOFTWARE_BREAK_OP_VECTOR;
				end
			end else if (!i_onchip_emulation_logic_software_break_op_en) begin
				// Break mode is left when the emulation logic withdraws it.
				brk_ff <= 1'b0;
			end
		end
	end

	// Every output is a plain copy of its register, so the core that
	// consumes these results never sees a combinational path from the
	// request inputs. The latency is therefore a fixed single cycle.
	// The write strobes are pulses of one cycle; the data words stand
	// until the next operation that writes them.
	// The flag word always mirrors the latest request, even for the
	// operations that leave the flags alone, but only the shifts raise
	// the flag write strobe.
	assign o_done = done_ff;
	assign o_result = result_ff;
	assign o_wr_en = wr_en_ff;
	assign o_wr_sel = wr_sel_ff;
	assign o_flags = flags_ff;
	assign o_flags_wr = flags_wr_ff;
	assign o_stack_pointer = sp_ff;
	assign o_sp_wr = sp_wr_ff;
	assign o_mem_addr = addr_ff;
	assign o_mem_wdata = wdata_ff;
	assign o_mem_wr = mem_wr_ff;
	assign o_break_mode = brk_ff;
	assign o_trap = trap_ff;
	assign o_trap_vector = vec_ff;

endmodule

//--- shared/srco_pkg.sv
package srco_pkg;

	// Width of the data word and of the shift count field.
	localparam int SRCO_W = 16;
	localparam int SRCO_CNT_W = 4;
	// Amount by which the context switch lowers the stack pointer.
	localparam logic [15:0] SRCO_SP_STEP = 16'h0002;
	// Trap vector raised by a software break when emulation break is off.
	localparam logic [7:0] SRCO_SOFTWARE_BREAK_OP_VECTOR = 8'h08;
	// Reset value of the result, stack pointer, address and write data words.
	localparam logic [15:0] SRCO_WORD_RST = 16'h0000;

	// Operation selector for the block.
	typedef enum logic [5:0] {
		SRCO_OP_NONE = 6'h01,
		SRCO_OP_ROR = 6'h02,
		SRCO_OP_SHL = 6'h04,
		SRCO_OP_SHR = 6'h08,
		SRCO_OP_SOFTWARE_BREAK_OP = 6'h10,
		SRCO_OP_CONTEXT_SWITCH_OP = 6'h20
	} srco_op_t;

	// Condition flags in the order E, Z, V, C, N.
	typedef struct packed {
		logic e;
		logic z;
		logic v;
		logic c;
		logic n;
	} srco_flags_t;

	// One request to the block.
	typedef struct packed {
		srco_op_t op;
		logic [15:0] op1;
		logic [15:0] op2;
		logic [3:0] reg_sel;
	} srco_req_t;

endpackage

//--- verilog/srco_shifter.sv
`timescale 1ns/1ps
// Combinational shifter for the rotate right and the two logical shifts.
module srco_shifter
	import srco_pkg::*;
#(
	parameter int W = 16
) (
	input wire srco_op_t i_op,
	input wire logic [W-1:0] i_val,
	input wire logic [15:0] i_cnt_raw,
	input wire logic i_v_old,
	output logic [W-1:0] o_res,
	output srco_flags_t o_flags
);

	// Count limited to the low four bits.
	logic [3:0] cnt;

	// Steps through the count one bit at a time, as the flags need it; the loop runs at most fifteen steps, so a count of fifteen shifts by fifteen.
	always_comb begin
		logic [W-1:0] v;
		logic c;
		logic ov;
		v = i_val;
		c = 1'b0;
		ov = 1'b0;
		cnt = i_cnt_raw[3:0]; // [RULE_16]
		for (int k = 0; k < 15; k++) begin
			if (k < int'(cnt)) begin
				if (i_op == SRCO_OP_SHL) begin
					c = v[W-1]; // [RULE_10]
					v = {v[W-2:0], 1'b0}; // [RULE_09]
				end else if (i_op == SRCO_OP_SHR) begin
					ov = ov | c; // [RULE_12]
					c = v[0];
					v = {1'b0, v[W-1:1]}; // [RULE_11]
				end else begin
					ov = ov | c; // [RULE_01]
					c = v[0]; // [RULE_02]
					v = {v[0], v[W-1:1]}; // [RULE_03]
				end
			end
		end
		// A zero count leaves the value unchanged and carry and overflow clear.
		o_res = v; // [RULE_17]
		o_flags.e = 1'b0; // [RULE_04]
		o_flags.z = (v == '0);
		o_flags.n = v[W-1];
		o_flags.c = c; // [RULE_13]
		o_flags.v = (i_op == SRCO_OP_SHL) ? 1'b0 : ov; // [RULE_14]
	end

	// The old overflow is deliberately not folded in: each operation
	// starts its sticky rounding indicator from zero.
	logic unused_v;
	assign unused_v = i_v_old;

endmodule

//--- sim/srco_props.sv
`timescale 1ns/1ps
// Ties each answer of the core to the request one cycle before it, except a_flag, which checks the flags against the result of the same cycle.
module srco_props
	import srco_pkg::*;
(
	input wire logic i_clk,
	input wire logic i_nrst,
	input wire logic i_valid,
	input wire srco_req_t i_req,
	input wire logic [15:0] i_stack_pointer,
	input wire logic i_onchip_emulation_logic_software_break_op_en,
	input wire logic [15:0] o_result,
	input wire logic o_wr_en,
	input wire srco_flags_t o_flags,
	input wire logic o_flags_wr,
	input wire logic [15:0] o_stack_pointer,
	input wire logic o_sp_wr,
	input wire logic [15:0] o_mem_addr,
	input wire logic [15:0] o_mem_wdata,
	input wire logic o_break_mode,
	input wire logic o_trap,
	input wire logic [7:0] o_trap_vector
);
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_nrst);
	sequence s_cx; i_valid && i_req.op == SRCO_OP_CONTEXT_SWITCH_OP; endsequence
	sequence s_brk; i_valid && i_req.op == SRCO_OP_SOFTWARE_BREAK_OP; endsequence
	sequence s_zero; i_valid && i_req.op2[3:0] == 4'h0 &&
		i_req.op inside {SRCO_OP_ROR, SRCO_OP_SHL, SRCO_OP_SHR}; endsequence
	property p_sp; s_cx |=> o_sp_wr &&
		o_stack_pointer == $past(i_stack_pointer) - SRCO_SP_STEP; endproperty
	a_sp: assert property (p_sp) else $error("bad sp");
	property p_push; s_cx |=> o_mem_addr == o_stack_pointer &&
		o_mem_wdata == $past(i_req.op1); endproperty
	a_push: assert property (p_push) else $error("bad push");
	property p_load; s_cx |=> o_wr_en && o_result == $past(i_req.op2);
		endproperty
	a_load: assert property (p_load) else $error("bad load");
	property p_brk; s_brk ##0 i_onchip_emulation_logic_software_break_op_en |=>
		o_break_mode && !o_trap; endproperty
	a_brk: assert property (p_brk) else $error("no break");
	property p_trap; s_brk ##0 !i_onchip_emulation_logic_software_break_op_en |=>
		o_trap && o_trap_vector == SRCO_SOFTWARE_BREAK_OP_VECTOR; endproperty
	a_trap: assert property (p_trap) else $error("no trap");
	property p_keep; s_brk |=> !o_flags_wr && !o_wr_en; endproperty
	a_keep: assert property (p_keep) else $error("flags hit");
	property p_flag; o_flags_wr |-> !o_flags.e && o_flags.n == o_result[15]
		&& o_flags.z == (o_result == 16'h0000); endproperty
	a_flag: assert property (p_flag) else $error("bad flags");
	property p_zero; s_zero |=> o_result == $past(i_req.op1) &&
		!o_flags.c && !o_flags.v; endproperty
	a_zero: assert property (p_zero) else $error("bad zero");
endmodule
bind srco_core srco_props u_props (.*);

//--- sim/srco_core_tb.sv
`timescale 1ns/1ps
`define CK(nm, e, g) begin \
	num_checks++; \
	if ((g) !== (e)) begin \
		n_errors++; \
		$display("wrong value %s exp %h got %h", nm, e, g); \
	end \
end
// Drives one request per call and checks the answer a cycle later.
module srco_core_tb import srco_pkg::*;;
	logic i_clk = 0, i_nrst = 0, i_valid = 0;
	logic i_onchip_emulation_logic_software_break_op_en = 0;
	srco_req_t i_req = '0;
	srco_flags_t i_flags = 5'h1F, o_flags, f;
	logic [15:0] i_stack_pointer = 16'h0000, o_result, r;
	logic [15:0] o_stack_pointer, o_mem_addr, o_mem_wdata;
	logic o_done, o_wr_en, o_flags_wr, o_sp_wr, o_mem_wr, o_break_mode;
	logic o_trap;
	logic [3:0] o_wr_sel;
	logic [7:0] o_trap_vector;
	int n_errors = 0, num_checks = 0, cyc = 0;
	srco_core dut (.*);
	always #12.5 i_clk = ~i_clk;
	// A hang ends the run as a failure.
	always @(posedge i_clk) begin
		cyc++;
		if (cyc == 999) begin
			n_errors++;
			stop_test();
		end
	end
	task go(input srco_op_t op, input logic [15:0] a, input logic [15:0] b);
		@(posedge i_clk);
		i_valid <= 1'b1;
		i_req <= '{op, a, b, 4'h5};
		@(posedge i_clk);
		i_valid <= 1'b0;
		#1;
	endtask
	// Steps the shift one bit at a time, as software would see it.
	task sh(input srco_op_t op, input logic [15:0] a, input logic [15:0] b);
		r = a;
		f = '0;
		for (int k = 0; k < b[3:0]; k++) begin
			if (op == SRCO_OP_SHL) begin
				f.c = r[15];
				r = r << 1;
			end else begin
				f.v = f.v | f.c;
				f.c = r[0];
				r = {op == SRCO_OP_ROR ? r[0] : 1'b0, r[15:1]};
			end
		end
		f.z = r == 16'h0000;
		f.n = r[15];
		go(op, a, b);
		`CK("result", r, o_result)
		`CK("flags", f, o_flags)
		`CK("shwr", 3'b111, {o_done, o_wr_en, o_flags_wr})
		`CK("wrsel", 4'h5, o_wr_sel)
	endtask
	task stop_test;
		$display("errors %0d checks %0d", n_errors, num_checks);
		if (n_errors == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge i_clk);
		i_nrst <= 1'b1;
		sh(SRCO_OP_ROR, 16'h8005, 16'h0003);
		sh(SRCO_OP_ROR, 16'h0001, 16'h0001);
		sh(SRCO_OP_ROR, 16'h1234, 16'h0000);
		sh(SRCO_OP_ROR, 16'hFFFF, 16'h000F);
		sh(SRCO_OP_SHL, 16'h4001, 16'h0012);
		sh(SRCO_OP_SHL, 16'h8001, 16'h000F);
		sh(SRCO_OP_SHL, 16'h1234, 16'h000F);
		sh(SRCO_OP_SHR, 16'h0008, 16'h0003);
		sh(SRCO_OP_SHR, 16'h00B6, 16'h0004);
		sh(SRCO_OP_SHR, 16'h8000, 16'h0000);
		sh(SRCO_OP_SHR, 16'hFFFF, 16'hFFF1);
		go(SRCO_OP_CONTEXT_SWITCH_OP, 16'hA5A5, 16'h5A5A);
		`CK("push", 16'hA5A5, o_mem_wdata)
		`CK("addr", 16'hFFFE, o_mem_addr)
		`CK("sp", 16'hFFFE, o_stack_pointer)
		`CK("strobes", 3'b111, {o_sp_wr, o_mem_wr, o_wr_en})
		`CK("load", 16'h5A5A, o_result)
		go(SRCO_OP_SOFTWARE_BREAK_OP, 16'h0000, 16'h0000);
		`CK("vector", 8'h08, o_trap_vector)
		`CK("trap", 2'b01, {o_break_mode, o_trap})
		`CK("kept", i_flags, o_flags)
		`CK("nowr", 1'b0, o_flags_wr)
		@(posedge i_clk);
		i_onchip_emulation_logic_software_break_op_en <= 1'b1;
		go(SRCO_OP_SOFTWARE_BREAK_OP, 16'h0000, 16'h0000);
		`CK("break", 2'b10, {o_break_mode, o_trap})
		stop_test();
	end
endmodule
